// ---- verilog/csc_cfg.svh ----
// offsets, bit positions, reset values and counts of the clock source select block
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// ****************************************
// register indexes (byte address = 4 x index)
// ****************************************
`define CSC_IDX_MULT 6'h00
`define CSC_IDX_REFDIV 6'h01
`define CSC_IDX_SRC_SEL 6'h05
`define CSC_IDX_PLLCTL 6'h06
`define CSC_IDX_STATUS 6'h08
// ****************************************
// clock_source_select fields
// ****************************************
`define CSC_B_SYNTH_SEL 7
`define CSC_B_PSEUDO 6
`define CSC_B_SYS_WAI 5
`define CSC_B_LOW_AMP 4
`define CSC_B_SYN_WAI 3
`define CSC_B_CORE_WAI 2
`define CSC_B_TICK_WAI 1
`define CSC_B_WD_WAI 0
// ****************************************
// pll control and status fields
// ****************************************
`define CSC_B_PLL_ON 6
`define CSC_B_AUTO 5
`define CSC_B_WIDE 4
`define CSC_B_ST_LOCK 0
`define CSC_B_ST_TRACK 1
`define CSC_B_ST_WAIT 2
`define CSC_B_ST_STOP 3
`define CSC_B_ST_SELF 4
// ****************************************
// reset values and counts
// ****************************************
`define CSC_RST_SRC_SEL 8'h00
`define CSC_RST_PLLCTL 8'h60
`define CSC_RST_MULT 6'h00
`define CSC_RST_REFDIV 4'h0
`define CSC_BUS_DIV 2
// output flops at reset: oscillator, system, core, tick and watchdog running, auto bandwidth on
`define CSC_RST_OUTS 13'h0ab4
`endif

// ---- verilog/csc_pkg.sv ----
// types of the clock source select block
package csc_pkg;
    typedef enum logic [1:0] {CSC_RUN, CSC_WAIT, CSC_STOP} csc_mode_e;
endpackage

// ---- verilog/csc_clock_select.sv ----
// clock source select register, wait/stop policy and wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
`include "csc_cfg.svh"
module csc_clock_select #(
    parameter int ADR_W = 8,
    parameter bit LOW_AMP_AVAIL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_pll_lock,
    input wire logic i_pll_track,
    input wire logic i_self_clock,
    input wire logic i_special_mode,
    input wire logic i_wait_req,
    input wire logic i_stop_req,
    output logic o_synth_clock_choose,
    output logic o_bus_clk_en,
    output logic o_osc_enable,
    output logic o_osc_low_amplitude,
    output logic o_system_clocks_run,
    output logic o_core_clock_run,
    output logic o_synth_powerdown,
    output logic o_auto_bandwidth,
    output logic o_wide_bandwidth,
    output logic o_tick_run,
    output logic o_tick_div_reset,
    output logic o_watchdog_run,
    output logic o_watchdog_div_reset,
    output logic [5:0] o_multiplier,
    output logic [3:0] o_ref_divider
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] pin_raw;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    assign pin_raw = {i_special_mode, i_self_clock, i_pll_track, i_pll_lock};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate
    logic lock_s;
    logic track_s;
    logic self_s;
    logic special_s;
    assign lock_s = pin_sync[0];
    assign track_s = pin_sync[1];
    assign self_s = pin_sync[2];
    assign special_s = pin_sync[3];
    // ****************************************
    // register state
    // ****************************************
    logic [7:0] clock_source_select;
    logic [7:0] next_clock_source_select;
    logic [7:0] pllctl;
    logic [7:0] next_pllctl;
    logic [5:0] mult;
    logic [5:0] next_mult;
    logic [3:0] refdiv;
    logic [3:0] next_refdiv;
    logic wd_written;
    logic next_wd_written;
    logic self_prev;
    logic next_self_prev;
    csc_pkg::csc_mode_e mode;
    csc_pkg::csc_mode_e next_mode;
    logic ack;
    logic next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic [5:0] idx;
    logic wr;
    logic wr_src_sel;
    logic wr_mult;
    logic pll_stable;
    logic wait_entry;
    logic stop_entry;
    logic self_entry;
    assign idx = i_wb_adr[7:2];
    // write lands at the edge where ack is sampled
    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ack & i_wb_sel[0];
    assign wr_src_sel = wr & (idx == `CSC_IDX_SRC_SEL);
    assign wr_mult = wr & (idx == `CSC_IDX_MULT);
    assign pll_stable = pllctl[`CSC_B_AUTO] ? lock_s : track_s;
    assign wait_entry = (mode == csc_pkg::CSC_RUN) & i_wait_req & ~i_stop_req;
    assign stop_entry = (mode == csc_pkg::CSC_RUN) & i_stop_req;
    assign self_entry = self_s & ~self_prev;
    always_comb begin
        next_clock_source_select = clock_source_select;
        next_pllctl = pllctl;
        next_mult = mult;
        next_refdiv = refdiv;
        next_wd_written = wd_written;
        next_self_prev = self_s;
        if (wr_src_sel) begin
            next_clock_source_select[6:1] = i_wb_dat[6:1];
            if (special_s || !wd_written) begin
                next_clock_source_select[`CSC_B_WD_WAI] = i_wb_dat[`CSC_B_WD_WAI];
                next_wd_written = 1'b1;
            end
            if (!i_wb_dat[`CSC_B_SYNTH_SEL] || pll_stable) begin
                next_clock_source_select[`CSC_B_SYNTH_SEL] = i_wb_dat[`CSC_B_SYNTH_SEL];
            end
        end
        if (self_entry || stop_entry || (wait_entry && clock_source_select[`CSC_B_SYN_WAI])) begin
            next_clock_source_select[`CSC_B_SYNTH_SEL] = 1'b0;
        end
        if (wr && idx == `CSC_IDX_PLLCTL) begin
            next_pllctl[`CSC_B_WIDE] = i_wb_dat[`CSC_B_WIDE];
            // pll on cannot change under a live selection
            if (!clock_source_select[`CSC_B_SYNTH_SEL]) begin
                next_pllctl[`CSC_B_PLL_ON] = i_wb_dat[`CSC_B_PLL_ON];
            end
            next_pllctl[`CSC_B_AUTO] = i_wb_dat[`CSC_B_AUTO];
        end
        if (next_clock_source_select[`CSC_B_SYN_WAI]) begin
            next_pllctl[`CSC_B_AUTO] = 1'b1;
        end
        if (wr_mult && !clock_source_select[`CSC_B_SYNTH_SEL]) begin
            next_mult = i_wb_dat[5:0];
        end
        if (wr && idx == `CSC_IDX_REFDIV && !clock_source_select[`CSC_B_SYNTH_SEL]) begin
            next_refdiv = i_wb_dat[3:0];
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clock_source_select <= `CSC_RST_SRC_SEL;
            pllctl <= `CSC_RST_PLLCTL;
            mult <= `CSC_RST_MULT;
            refdiv <= `CSC_RST_REFDIV;
            wd_written <= 1'b0;
            self_prev <= 1'b0;
        end else begin
            clock_source_select <= next_clock_source_select;
            pllctl <= next_pllctl;
            mult <= next_mult;
            refdiv <= next_refdiv;
            wd_written <= next_wd_written;
            self_prev <= next_self_prev;
        end
    end
    // ****************************************
    // wishbone slave
    // ****************************************
    always_comb begin
        next_ack = i_wb_cyc & i_wb_stb & ~ack;
        next_rdat = 32'h0000_0000;
        unique case (idx)
            `CSC_IDX_SRC_SEL: next_rdat[7:0] = clock_source_select;
            `CSC_IDX_MULT: next_rdat[5:0] = mult;
            `CSC_IDX_REFDIV: next_rdat[3:0] = refdiv;
            `CSC_IDX_PLLCTL: next_rdat[7:0] = pllctl & 8'h70;
            `CSC_IDX_STATUS: next_rdat[4:0] = {self_s, mode == csc_pkg::CSC_STOP,
                                              mode == csc_pkg::CSC_WAIT, track_s, lock_s};
            default: next_rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end else begin
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end
    assign o_wb_ack = ack;
    assign o_wb_dat = rdat;
    // ****************************************
    // low power modes and clock policy
    // ****************************************
    logic bus_phase;
    logic next_bus_phase;
    logic [12:0] outs;
    logic [12:0] next_outs;
    logic in_wait;
    logic in_stop;
    logic sys_run;
    assign in_wait = (mode == csc_pkg::CSC_WAIT);
    assign in_stop = (mode == csc_pkg::CSC_STOP);
    assign sys_run = ~in_stop & ~(in_wait & clock_source_select[`CSC_B_SYS_WAI]);
    always_comb begin
        next_mode = mode;
        unique case (mode)
            csc_pkg::CSC_RUN: begin
                if (i_stop_req) begin
                    next_mode = csc_pkg::CSC_STOP;
                end else if (i_wait_req) begin
                    next_mode = csc_pkg::CSC_WAIT;
                end
            end
            csc_pkg::CSC_WAIT: begin
                if (!i_wait_req) begin
                    next_mode = csc_pkg::CSC_RUN;
                end
            end
            csc_pkg::CSC_STOP: begin
                if (!i_stop_req) begin
                    next_mode = csc_pkg::CSC_RUN;
                end
            end
        endcase
        // bus clock is the source halved
        next_bus_phase = sys_run ? ~bus_phase : 1'b0;
        next_outs[0] = clock_source_select[`CSC_B_SYNTH_SEL];
        next_outs[1] = sys_run & bus_phase;
        // oscillator off in stop unless pseudo-halt
        next_outs[2] = ~in_stop | clock_source_select[`CSC_B_PSEUDO];
        next_outs[3] = LOW_AMP_AVAIL & ((in_wait & clock_source_select[`CSC_B_LOW_AMP]) |
                                        (in_stop & clock_source_select[`CSC_B_PSEUDO]));
        next_outs[4] = sys_run;
        next_outs[5] = ~in_stop & ~(in_wait & clock_source_select[`CSC_B_CORE_WAI]);
        // pll powered down, pll on bit untouched
        next_outs[6] = ~pllctl[`CSC_B_PLL_ON] | in_stop | (in_wait & clock_source_select[`CSC_B_SYN_WAI]);
        next_outs[7] = pllctl[`CSC_B_AUTO];
        next_outs[8] = pllctl[`CSC_B_AUTO] ? ~track_s : pllctl[`CSC_B_WIDE];
        // tick halts and resets on wait when CSC_B_TICK_WAI is set
        next_outs[9] = ~in_stop & ~(in_wait & clock_source_select[`CSC_B_TICK_WAI]);
        next_outs[10] = wait_entry & clock_source_select[`CSC_B_TICK_WAI];
        // watchdog halts and resets on wait when CSC_B_WD_WAI is set
        next_outs[11] = ~in_stop & ~(in_wait & clock_source_select[`CSC_B_WD_WAI]);
        next_outs[12] = wait_entry & clock_source_select[`CSC_B_WD_WAI];
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode <= csc_pkg::CSC_RUN;
            bus_phase <= 1'b0;
            outs <= `CSC_RST_OUTS;
        end else begin
            mode <= next_mode;
            bus_phase <= next_bus_phase;
            outs <= next_outs;
        end
    end
    // pll on resets high so the pll does not start powered down
    assign o_synth_clock_choose = outs[0];
    assign o_bus_clk_en = outs[1];
    assign o_osc_enable = outs[2];
    assign o_osc_low_amplitude = outs[3];
    assign o_system_clocks_run = outs[4];
    assign o_core_clock_run = outs[5];
    assign o_synth_powerdown = outs[6];
    assign o_auto_bandwidth = outs[7];
    assign o_wide_bandwidth = outs[8];
    assign o_tick_run = outs[9];
    assign o_tick_div_reset = outs[10];
    assign o_watchdog_run = outs[11];
    assign o_watchdog_div_reset = outs[12];
    assign o_multiplier = mult;
    assign o_ref_divider = refdiv;
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_wait_in;
        wait_entry && clock_source_select[`CSC_B_TICK_WAI];
    endsequence
    sequence s_pulse;
        o_tick_div_reset ##1 !o_tick_div_reset;
    endsequence
    a_sel_unstable: assert property ((wr_src_sel && i_wb_dat[7] && !pll_stable && !clock_source_select[7])
        |=> !clock_source_select[7])
        else $error("unstable pll selected");
    a_sel_stop_clear: assert property (stop_entry |=> !clock_source_select[7] ##1 !o_synth_clock_choose)
        else $error("select kept on stop entry");
    a_bus_half: assert property (o_bus_clk_en |=> !o_bus_clk_en)
        else $error("bus enable not halved");
    a_osc_stop: assert property ((in_stop && !clock_source_select[6]) |=> !o_osc_enable)
        else $error("oscillator on in full stop");
    a_sel_no_restore: assert property ((in_wait && !clock_source_select[7] && !wr_src_sel)
        |=> !clock_source_select[7])
        else $error("select restored by hardware");
    a_auto_held: assert property (clock_source_select[3] |-> pllctl[5])
        else $error("auto bandwidth dropped");
    a_core_halt: assert property ((in_wait && clock_source_select[2]) |=> !o_core_clock_run)
        else $error("core clock runs in wait");
    a_tick_reset: assert property (s_wait_in |=> s_pulse)
        else $error("tick divider reset missing");
    a_wd_once: assert property ((wr_src_sel && wd_written && !special_s) |=> $stable(clock_source_select[0]))
        else $error("watchdog bit rewritten");
    a_mult_locked: assert property ((wr_mult && clock_source_select[7]) |=> $stable(mult))
        else $error("multiplier written while selected");
endmodule // csc_clock_select

// ---- verification/csc_clock_select_tb.sv ----
// self-checking bench of the clock source select block
`timescale 1ns/1ns
module csc_clock_select_tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic o_wb_ack, o_synth_clock_choose, o_bus_clk_en, o_osc_enable, o_osc_low_amplitude;
    logic o_system_clocks_run, o_core_clock_run, o_synth_powerdown, o_auto_bandwidth;
    logic o_wide_bandwidth, o_tick_run, o_tick_div_reset, o_watchdog_run, o_watchdog_div_reset;
    logic [31:0] o_wb_dat;
    logic [5:0] o_multiplier;
    logic [3:0] o_ref_divider;
    logic pll_lock = 1'b0;
    logic pll_track = 1'b1;
    logic self_clk = 1'b0;
    logic special = 1'b0;
    logic wait_req = 1'b0;
    logic stop_req = 1'b0;
    logic [7:0] flags;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int bus_cnt = 0;
    int tick_cnt = 0;
    int wd_cnt = 0;
    int c0;
    int c1;
    // one byte of run, oscillator, powerdown and select levels
    assign flags = {o_system_clocks_run, o_core_clock_run, o_tick_run, o_watchdog_run,
                    o_osc_enable, o_osc_low_amplitude, o_synth_powerdown, o_synth_clock_choose};
    always #5 i_clk = ~i_clk;
    csc_clock_select DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_ack(o_wb_ack),
        .o_wb_dat(o_wb_dat), .i_pll_lock(pll_lock), .i_pll_track(pll_track), .i_self_clock(self_clk),
        .i_special_mode(special), .i_wait_req(wait_req), .i_stop_req(stop_req),
        .o_synth_clock_choose(o_synth_clock_choose), .o_bus_clk_en(o_bus_clk_en),
        .o_osc_enable(o_osc_enable), .o_osc_low_amplitude(o_osc_low_amplitude),
        .o_system_clocks_run(o_system_clocks_run), .o_core_clock_run(o_core_clock_run),
        .o_synth_powerdown(o_synth_powerdown), .o_auto_bandwidth(o_auto_bandwidth),
        .o_wide_bandwidth(o_wide_bandwidth), .o_tick_run(o_tick_run), .o_tick_div_reset(o_tick_div_reset),
        .o_watchdog_run(o_watchdog_run), .o_watchdog_div_reset(o_watchdog_div_reset),
        .o_multiplier(o_multiplier), .o_ref_divider(o_ref_divider));
    // ****************************************
    // counters, timeout and tasks
    // ****************************************
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        bus_cnt <= bus_cnt + int'(o_bus_clk_en === 1'b1);
        tick_cnt <= tick_cnt + int'(o_tick_div_reset === 1'b1);
        wd_cnt <= wd_cnt + int'(o_watchdog_div_reset === 1'b1);
        // far past the 170 or so cycles the sequence needs
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // classic cycle: held until ack is sampled, then one idle cycle
    task xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rdat);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_dat <= {24'h000000, dat};
        @(posedge i_clk);
        while (o_wb_ack !== 1'b1) @(posedge i_clk);
        rdat = o_wb_dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
        @(posedge i_clk);
    endtask
    task wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        xfer(1'b1, adr, dat, d);
    endtask
    task rchk(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, adr, 8'h00, d);
        check(d, {24'h000000, exp});
    endtask
    task idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        idle(6);
        i_rst <= 1'b0;
        idle(1);
        rchk(8'h14, 8'h00);
        check({24'h0, flags}, 32'hf8);
        rchk(8'h0c, 8'h00);
        wr(8'h14, 8'h01);
        wr(8'h14, 8'h00);
        rchk(8'h14, 8'h01);
        // auto on: tracking alone must not allow selection
        wr(8'h14, 8'h81);
        rchk(8'h14, 8'h01);
        wr(8'h18, 8'h50);
        // output flops follow the register one cycle after the write
        idle(1);
        check({31'h0, o_wide_bandwidth}, 32'h1);
        pll_lock <= 1'b1;
        pll_track <= 1'b0;
        idle(4);
        wr(8'h14, 8'h81);
        rchk(8'h14, 8'h01);
        pll_track <= 1'b1;
        idle(4);
        wr(8'h14, 8'h81);
        rchk(8'h14, 8'h81);
        check({24'h0, flags}, 32'hf9);
        c0 = bus_cnt;
        idle(20);
        check(32'(bus_cnt - c0), 32'd10);
        wr(8'h00, 8'h3f);
        rchk(8'h00, 8'h00);
        check({26'h0, o_multiplier}, 32'h0);
        wr(8'h04, 8'h0f);
        check({28'h0, o_ref_divider}, 32'h0);
        wr(8'h18, 8'h70);
        idle(1);
        check({30'h0, o_auto_bandwidth, o_wide_bandwidth}, 32'h2);
        self_clk <= 1'b1;
        idle(5);
        rchk(8'h14, 8'h01);
        self_clk <= 1'b0;
        idle(4);
        wr(8'h14, 8'h81);
        stop_req <= 1'b1;
        idle(3);
        check({24'h0, flags}, 32'h02);
        stop_req <= 1'b0;
        idle(2);
        rchk(8'h14, 8'h01);
        wr(8'h04, 8'h0a);
        wr(8'h00, 8'h15);
        check({28'h0, o_ref_divider}, 32'ha);
        check({26'h0, o_multiplier}, 32'h15);
        wr(8'h14, 8'h41);
        stop_req <= 1'b1;
        idle(3);
        check({24'h0, flags}, 32'h0e);
        stop_req <= 1'b0;
        wr(8'h14, 8'h37);
        c0 = tick_cnt;
        c1 = wd_cnt;
        wait_req <= 1'b1;
        idle(3);
        check({24'h0, flags}, 32'h0c);
        check(32'(tick_cnt - c0), 32'd1);
        check(32'(wd_cnt - c1), 32'd1);
        wait_req <= 1'b0;
        wr(8'h14, 8'h20);
        c0 = tick_cnt;
        wait_req <= 1'b1;
        idle(3);
        check({24'h0, flags}, 32'h68);
        check(32'(tick_cnt - c0), 32'd0);
        wait_req <= 1'b0;
        // auto cleared first, then forced back by the powerdown-wait bit
        wr(8'h18, 8'h40);
        wr(8'h14, 8'h88);
        rchk(8'h18, 8'h60);
        rchk(8'h14, 8'h89);
        wait_req <= 1'b1;
        idle(3);
        check({24'h0, flags}, 32'hea);
        rchk(8'h18, 8'h60);
        rchk(8'h20, 8'h07);
        wait_req <= 1'b0;
        idle(3);
        rchk(8'h14, 8'h09);
        special <= 1'b1;
        idle(4);
        wr(8'h14, 8'h00);
        rchk(8'h14, 8'h00);
        stop_test();
    end
endmodule // csc_clock_select_tb
